//--- rtl/mex_pkg.sv
package mex_pkg;

  // ****************************************************************
  // register map, byte addresses on the apb side
  // ****************************************************************
  localparam int           MEX_AW        = 12;
  localparam logic [11:0]  MEX_CTRL_OFS  = 12'h000;
  localparam logic [11:0]  MEX_INSTR_OFS = 12'h004;
  localparam logic [11:0]  MEX_STAT_OFS  = 12'h008;
  localparam logic [11:0]  MEX_ACC_OFS   = 12'h00c;
  localparam logic [11:0]  MEX_FLAG_OFS  = 12'h010;
  localparam logic [11:0]  MEX_TPTR_OFS  = 12'h014;
  localparam logic [11:0]  MEX_TUPR_OFS  = 12'h018;
  localparam logic [11:0]  MEX_PC_OFS    = 12'h01c;
  localparam logic [11:0]  MEX_MADR_OFS  = 12'h020;
  localparam logic [11:0]  MEX_MDAT_OFS  = 12'h024;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MEX_CTRL_GO_BIT  = 0;
  localparam int MEX_INSTR_OP_LSB = 0;
  localparam int MEX_INSTR_BS_LSB = 8;
  localparam int MEX_INSTR_AD_LSB = 16;
  localparam int MEX_INSTR_IM_LSB = 24;
  localparam int MEX_STAT_BUSY    = 0;
  localparam int MEX_STAT_SKIP    = 1;
  localparam int MEX_STAT_DUMMY   = 2;

  // ****************************************************************
  // reset values and constants
  // ****************************************************************
  localparam logic [7:0]  MEX_ACC_RST   = 8'h00;
  localparam logic [5:0]  MEX_FLAG_RST  = 6'h00;
  localparam logic [7:0]  MEX_TPTR_RST  = 8'h00;
  localparam logic [7:0]  MEX_TUPR_RST  = 8'h00;
  localparam logic [11:0] MEX_PC_RST    = 12'h000;
  localparam logic [7:0]  MEX_ALL_ONES  = 8'hff;
  localparam logic [7:0]  MEX_ONE       = 8'h01;

  typedef enum logic [4:0] {
    MEX_NOP, sub_acc_mem_op, minus_to_mem_op, sub_acc_imm_op,
    xor_acc_mem_op, bitdiff_to_mem_op, xor_acc_imm_op,
    decr_acc_skip_op, incr_skip_op, incr_acc_skip_op,
    set_byte_op, set_bit_op, skip_bit_high_op, skip_bit_low_op,
    skip_on_null_op, copy_skip_null_op, nibble_flip_op, nibble_flip_acc_op,
    rom_read_cur_page_op, rom_read_final_page_op
  } mex_op_t;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic powerdown_flag;
    logic signed_wrap_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } mex_flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
    logic [2:0] bsel;
    mex_op_t    op;
  } mex_instr_t;

  typedef struct packed {
    logic       acc_we;
    logic       mem_we;
    logic [7:0] acc_val;
    logic [7:0] mem_val;
    logic       skip;
    mex_flags_t flags;
  } mex_res_t;

endpackage

//--- rtl/mex_alu.sv
`timescale 1ns/100ps
module mex_alu
  import mex_pkg::*;
(
  input  wire mex_op_t    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] mem,
  input  wire logic [7:0] imm,
  input  wire logic [2:0] bsel,
  input  wire mex_flags_t flg_in,
  output      mex_res_t   res
);

  // ****************************************************************
  // subtract as acc + ~b + 1, returns {ov, ac, c, result}
  // ****************************************************************
  function automatic logic [10:0] mex_sub(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    logic       ov;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    ov   = (a[7] != b[7]) && (full[7] != a[7]);
    return {ov, low[4], full[8], full[7:0]};
  endfunction

  logic [10:0] sub_m;
  logic [10:0] sub_x;
  logic [7:0]  dec_v;
  logic [7:0]  inc_v;
  logic [7:0]  bit_mask;

  assign sub_m    = mex_sub(acc, mem);
  assign sub_x    = mex_sub(acc, imm);
  assign dec_v    = mem - MEX_ONE;
  assign inc_v    = mem + MEX_ONE;
  assign bit_mask = MEX_ONE << bsel;

  always_comb
  begin
    res         = '0;
    res.flags   = flg_in;
    res.acc_val = acc;
    res.mem_val = mem;
    case (op)
      sub_acc_mem_op, minus_to_mem_op:
      begin
        res.acc_we  = (op == sub_acc_mem_op);
        res.mem_we  = (op == minus_to_mem_op);
        res.acc_val = sub_m[7:0];
        res.mem_val = sub_m[7:0];
        res.flags.signed_wrap_flag  = sub_m[10];
        res.flags.nibble_carry_flag = sub_m[9];
        res.flags.c                 = sub_m[8];
        res.flags.z                 = (sub_m[7:0] == 8'h00);
      end
      sub_acc_imm_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = sub_x[7:0];
        res.flags.signed_wrap_flag  = sub_x[10];
        res.flags.nibble_carry_flag = sub_x[9];
        res.flags.c                 = sub_x[8];
        res.flags.z                 = (sub_x[7:0] == 8'h00);
      end
      xor_acc_mem_op, bitdiff_to_mem_op:
      begin
        res.acc_we  = (op == xor_acc_mem_op);
        res.mem_we  = (op == bitdiff_to_mem_op);
        res.acc_val = acc ^ mem;
        res.mem_val = acc ^ mem;
        res.flags.z = ((acc ^ mem) == 8'h00);
      end
      xor_acc_imm_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = acc ^ imm;
        res.flags.z = ((acc ^ imm) == 8'h00);
      end
      decr_acc_skip_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = dec_v;
        res.skip    = (dec_v == 8'h00);
      end
      incr_skip_op:
      begin
        res.mem_we  = 1'b1;
        res.mem_val = inc_v;
        res.skip    = (inc_v == 8'h00);
      end
      incr_acc_skip_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = inc_v;
        res.skip    = (inc_v == 8'h00);
      end
      set_byte_op:
      begin
        res.mem_we  = 1'b1;
        res.mem_val = MEX_ALL_ONES;
      end
      set_bit_op:
      begin
        res.mem_we  = 1'b1;
        res.mem_val = mem | bit_mask;
      end
      skip_bit_high_op: res.skip = |(mem & bit_mask);
      skip_bit_low_op:  res.skip = ~|(mem & bit_mask);
      skip_on_null_op:  res.skip = (mem == 8'h00);
      copy_skip_null_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = mem;
        res.skip    = (mem == 8'h00);
      end
      nibble_flip_op:
      begin
        res.mem_we  = 1'b1;
        res.mem_val = {mem[3:0], mem[7:4]};
      end
      nibble_flip_acc_op:
      begin
        res.acc_we  = 1'b1;
        res.acc_val = {mem[3:0], mem[7:4]};
      end
      default: res.skip = 1'b0;
    endcase
  end

endmodule // mex_alu

//--- rtl/mex_core.sv
// Summary of operation
// - decrement-to-acc: acc gets mem minus one, memory kept, skip on zero
// - a taken skip discards the fetched word and adds one dummy cycle
// - byte set writes all ones to the addressed location
// - bit set raises only the selected bit, other seven kept
// - increment-and-skip writes mem plus one back, skip when it wraps to zero
// - increment-to-acc: acc gets mem plus one, memory kept, skip on zero
// - skip when selected bit is one, nothing modified
// - memory subtract: acc plus inverted mem plus one, to acc or mem, four flags
// - immediate subtract: acc plus inverted immediate plus one, four flags
// - in-place nibble swap, no flag changes
// - nibble swap into acc, memory kept
// - skip when whole byte is zero, nothing modified
// - copy byte to acc, skip when it is zero
// - skip when selected bit is zero, nothing modified
// - current-page table read: low byte to memory, high byte to upper latch
// - last-page table read: low byte to memory, high byte to upper latch
// - xor acc with memory into acc, zero flag only
// - xor acc with memory into memory, zero flag only
// - xor acc with immediate into acc, zero flag
`timescale 1ns/100ps
module mex_core
  import mex_pkg::*;
#(
  parameter int DMEM_DEPTH = 208,
  parameter int ROM_AW     = 12,
  parameter int ROM_DW     = 15
)
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [MEX_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  output      logic [ROM_AW-1:0] rom_addr,
  output      logic              rom_rd,
  input  wire logic [ROM_DW-1:0] rom_rdata,
  output      logic              exec_busy,
  output      logic              skip_taken
);

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum {MEX_IDLE, MEX_EXEC, MEX_TBL, MEX_DUMMY} mex_state_t;

  localparam int PAGE_W = ROM_AW - 8;

  mex_state_t         state_reg;
  mex_instr_t         instr_reg;
  logic [7:0]         acc_reg;
  mex_flags_t         flags_reg;
  logic [7:0]         tptr_reg;
  logic [7:0]         tupr_reg;
  logic [ROM_AW-1:0]  pc_reg;
  logic [7:0]         madr_reg;
  logic               skip_reg;
  logic [7:0]         dmem_reg [DMEM_DEPTH];
  logic [31:0]        prdata_reg;
  logic               pslverr_reg;
  logic [ROM_AW-1:0]  rom_addr_reg;
  logic               rom_rd_reg;

  logic               apb_setup;
  logic               apb_access;
  logic               wr_ok;
  logic               go;
  logic [7:0]         mem_rd;
  logic [7:0]         sw_mem_rd;
  mex_res_t           res;
  logic               tbl_op;
  logic [ROM_AW-1:0]  tbl_addr;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic in_range(input logic [7:0] a);
    return (32'(a) < DMEM_DEPTH);
  endfunction

  function automatic logic [7:0] mem_peek(input logic [7:0] a,
                                          input logic [7:0] m [DMEM_DEPTH]);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < DMEM_DEPTH; i++)
    begin
      if (32'(a) == i)
      begin
        v = m[i];
      end
    end
    return v;
  endfunction

  function automatic logic is_reg(input logic [MEX_AW-1:0] a);
    case (a)
      MEX_CTRL_OFS, MEX_INSTR_OFS, MEX_STAT_OFS, MEX_ACC_OFS, MEX_FLAG_OFS,
      MEX_TPTR_OFS, MEX_TUPR_OFS, MEX_PC_OFS, MEX_MADR_OFS, MEX_MDAT_OFS:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait states: read data and error are settled in the setup cycle
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign pready     = 1'b1;
  assign prdata     = prdata_reg;
  assign pslverr    = pslverr_reg;
  // the error decided at setup also blocks the write, so both always agree
  assign wr_ok      = apb_access && pwrite && !pslverr_reg;
  assign go         = wr_ok && (paddr == MEX_CTRL_OFS) && pwdata[MEX_CTRL_GO_BIT];

  assign sw_mem_rd  = mem_peek(madr_reg, dmem_reg);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (apb_setup)
    begin
      // software may not disturb an instruction in flight
      pslverr_reg <= !is_reg(paddr) ||
                     (pwrite && (state_reg != MEX_IDLE) && (paddr != MEX_STAT_OFS));
      prdata_reg  <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          MEX_INSTR_OFS: prdata_reg <= {instr_reg.imm, instr_reg.addr, 5'h00,
                                        instr_reg.bsel, 3'h0, instr_reg.op};
          MEX_STAT_OFS:  prdata_reg <= {29'h0, (state_reg == MEX_DUMMY),
                                        skip_reg, (state_reg != MEX_IDLE)};
          MEX_ACC_OFS:   prdata_reg <= {24'h0, acc_reg};
          MEX_FLAG_OFS:  prdata_reg <= {26'h0, flags_reg};
          MEX_TPTR_OFS:  prdata_reg <= {24'h0, tptr_reg};
          MEX_TUPR_OFS:  prdata_reg <= {24'h0, tupr_reg};
          MEX_PC_OFS:    prdata_reg <= {{(32-ROM_AW){1'b0}}, pc_reg};
          MEX_MADR_OFS:  prdata_reg <= {24'h0, madr_reg};
          MEX_MDAT_OFS:  prdata_reg <= {24'h0, sw_mem_rd};
          default:       prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // software-owned registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      instr_reg <= '0;
      tptr_reg  <= MEX_TPTR_RST;
      madr_reg  <= 8'h00;
    end
    else if (wr_ok)
    begin
      case (paddr)
        MEX_INSTR_OFS:
        begin
          instr_reg.op   <= mex_op_t'(pwdata[MEX_INSTR_OP_LSB +: 5]);
          instr_reg.bsel <= pwdata[MEX_INSTR_BS_LSB +: 3];
          instr_reg.addr <= pwdata[MEX_INSTR_AD_LSB +: 8];
          instr_reg.imm  <= pwdata[MEX_INSTR_IM_LSB +: 8];
        end
        MEX_TPTR_OFS: tptr_reg <= pwdata[7:0];
        MEX_MADR_OFS: madr_reg <= pwdata[7:0];
        default:      madr_reg <= madr_reg;
      endcase
    end
  end

  // ****************************************************************
  // datapath
  // ****************************************************************
  assign mem_rd = mem_peek(instr_reg.addr, dmem_reg);
  assign tbl_op = (instr_reg.op == rom_read_cur_page_op) ||
                  (instr_reg.op == rom_read_final_page_op);
  // last page is the top page of program memory
  assign tbl_addr = (instr_reg.op == rom_read_final_page_op) ?
                    {{PAGE_W{1'b1}}, tptr_reg} :
                    {pc_reg[ROM_AW-1:8], tptr_reg};

  mex_alu u_alu (
    .op     (instr_reg.op),
    .acc    (acc_reg),
    .mem    (mem_rd),
    .imm    (instr_reg.imm),
    .bsel   (instr_reg.bsel),
    .flg_in (flags_reg),
    .res    (res)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= MEX_IDLE;
    end
    else
    begin
      case (state_reg)
        MEX_IDLE:  state_reg <= go ? MEX_EXEC : MEX_IDLE;
        MEX_EXEC:
        begin
          if (tbl_op)
          begin
            state_reg <= MEX_TBL;
          end
          else if (res.skip)
          begin
            state_reg <= MEX_DUMMY;
          end
          else
          begin
            state_reg <= MEX_IDLE;
          end
        end
        MEX_TBL:   state_reg <= MEX_IDLE;
        MEX_DUMMY: state_reg <= MEX_IDLE;
        default:   state_reg <= MEX_IDLE;
      endcase
    end
  end

  // skip result of the last instruction, held until the next one starts
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      skip_reg <= 1'b0;
    end
    else if (state_reg == MEX_EXEC)
    begin
      skip_reg <= res.skip && !tbl_op;
    end
    else if (go)
    begin
      skip_reg <= 1'b0;
    end
  end

  // program counter: a taken skip steps over the discarded word
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pc_reg <= MEX_PC_RST;
    end
    else if (wr_ok && (paddr == MEX_PC_OFS))
    begin
      pc_reg <= pwdata[ROM_AW-1:0];
    end
    else if (state_reg == MEX_EXEC)
    begin
      pc_reg <= pc_reg + ROM_AW'(1);
    end
    else if (state_reg == MEX_DUMMY)
    begin
      pc_reg <= pc_reg + ROM_AW'(1);
    end
  end

  // ****************************************************************
  // accumulator and flags
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_reg <= MEX_ACC_RST;
    end
    else if (wr_ok && (paddr == MEX_ACC_OFS))
    begin
      acc_reg <= pwdata[7:0];
    end
    else if ((state_reg == MEX_EXEC) && res.acc_we)
    begin
      acc_reg <= res.acc_val;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_reg <= mex_flags_t'(MEX_FLAG_RST);
    end
    else if (wr_ok && (paddr == MEX_FLAG_OFS))
    begin
      flags_reg <= mex_flags_t'(pwdata[5:0]);
    end
    else if (state_reg == MEX_EXEC)
    begin
      flags_reg <= res.flags;
    end
  end

  // ****************************************************************
  // table read
  // ****************************************************************
  // program memory answers while the registered strobe stands
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_addr_reg <= '0;
      rom_rd_reg   <= 1'b0;
    end
    else
    begin
      rom_rd_reg <= (state_reg == MEX_EXEC) && tbl_op;
      if ((state_reg == MEX_EXEC) && tbl_op)
      begin
        rom_addr_reg <= tbl_addr;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tupr_reg <= MEX_TUPR_RST;
    end
    else if (state_reg == MEX_TBL)
    begin
      tupr_reg <= 8'(rom_rdata[ROM_DW-1:8]);
    end
  end

  // ****************************************************************
  // data memory
  // ****************************************************************
  // out-of-range addresses drop writes and read as zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DMEM_DEPTH; i++)
      begin
        dmem_reg[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < DMEM_DEPTH; i++)
      begin
        if ((state_reg == MEX_EXEC) && res.mem_we && (32'(instr_reg.addr) == i))
        begin
          dmem_reg[i] <= res.mem_val;
        end
        else if ((state_reg == MEX_TBL) && (32'(instr_reg.addr) == i))
        begin
          dmem_reg[i] <= rom_rdata[7:0];
        end
        else if (wr_ok && (paddr == MEX_MDAT_OFS) && in_range(madr_reg) &&
                 (32'(madr_reg) == i))
        begin
          dmem_reg[i] <= pwdata[7:0];
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rom_addr   = rom_addr_reg;
  assign rom_rd     = rom_rd_reg;
  assign exec_busy  = (state_reg != MEX_IDLE);
  assign skip_taken = (state_reg == MEX_DUMMY);

endmodule // mex_core

//--- bench/mex_core_asserts.sv
`timescale 1ns/100ps
module mex_core_asserts
  import mex_pkg::*;
#(
  parameter int ROM_AW = 12,
  parameter int ROM_DW = 15
)
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [MEX_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic              rom_rd,
  input wire logic [ROM_DW-1:0] rom_rdata,
  input wire logic              exec_busy,
  input wire logic              skip_taken
);
  // ****************************************************************
  // execution timing and unmapped apb access
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_go;
    psel && penable && pwrite && paddr == MEX_CTRL_OFS && pwdata[0] && !exec_busy && !pslverr;
  endsequence
  sequence s_skip;
    exec_busy ##1 skip_taken;
  endsequence
  property p_go; s_go |=> exec_busy; endproperty
  a_go: assert property (p_go) else $error("go did not start execution");
  property p_len; $rose(exec_busy) |-> ##[1:2] !exec_busy; endproperty
  a_len: assert property (p_len) else $error("execution longer than two cycles");
  property p_dummy; s_skip |=> !skip_taken && !exec_busy; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle not single");
  property p_skip_in; skip_taken |-> exec_busy && $past(exec_busy); endproperty
  a_skip_in: assert property (p_skip_in) else $error("skip outside execution");
  property p_rd_pulse; rom_rd |-> !skip_taken ##1 (!rom_rd && !exec_busy); endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rom strobe not a pulse");
  property p_rd_busy; rom_rd |-> exec_busy && $past(exec_busy); endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("rom strobe while idle");
  property p_addr_hold; !rom_rd |-> $stable(rom_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("rom address moved");
  property p_unmapped; psel && !penable && paddr > MEX_MDAT_OFS |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule // mex_core_asserts

//--- bench/mex_rom_model.sv
`timescale 1ns/100ps
module mex_rom_model
#(
  parameter int ROM_AW = 12,
  parameter int ROM_DW = 15
)
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic              rom_rd,
  output     logic [ROM_DW-1:0] rom_rdata
);
  function automatic logic [ROM_DW-1:0] word(input logic [ROM_AW-1:0] a);
    return ROM_DW'({a, 3'h0} ^ {3'h0, a} ^ 15'h2b5e);
  endfunction
  logic [ROM_DW-1:0] churn_reg;
  // word stands only while the strobe does, churns otherwise to expose late capture
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      churn_reg <= '0;
    else
      churn_reg <= ~churn_reg;
  end
  assign rom_rdata = rom_rd ? word(rom_addr) : churn_reg;
endmodule // mex_rom_model

//--- bench/mcu_exec_skip_sub_xor_tbl_test.sv
`timescale 1ns/100ps
module mcu_exec_skip_sub_xor_tbl_test
  import mex_pkg::*;
;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, rom_rd, exec_busy, skip_taken;
  logic [11:0] paddr, rom_addr;
  logic [31:0] pwdata, prdata, q;
  logic [14:0] rom_rdata;
  logic [7:0]  tupr_last;
  logic        err;
  int          n_fail, checks, busy_cnt;

  mex_core DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_rdata(rom_rdata), .exec_busy(exec_busy),
    .skip_taken(skip_taken));
  mex_rom_model u_rom (.mclk(mclk), .nrst(nrst), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_rdata(rom_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (exec_busy === 1'b1) busy_cnt <= busy_cnt + 1;

  task report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // called at a rising edge, returns at one with the bus idle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask

  task calc(input mex_op_t op, input logic [7:0] acc, mem, imm, tp, input logic [2:0] bs,
            input logic [11:0] pc, inout logic [7:0] ea, em, th, inout logic [5:0] ef,
            output logic sk);
    logic [8:0]  r;
    logic [4:0]  h;
    logic [7:0]  sb;
    logic [14:0] w;
    sk = 1'b0;
    sb = (op inside {sub_acc_imm_op, xor_acc_imm_op}) ? imm : mem;
    r = {1'b0, acc} + {1'b0, ~sb} + 9'h1;
    h = {1'b0, acc[3:0]} + {1'b0, ~sb[3:0]} + 5'h1;
    case (op)
      sub_acc_mem_op, minus_to_mem_op, sub_acc_imm_op:
      begin
        if (op == minus_to_mem_op) em = r[7:0]; else ea = r[7:0];
        ef[3:0] = {(acc[7] != sb[7]) && (r[7] != acc[7]), r[7:0] == 8'h0, h[4], r[8]};
      end
      xor_acc_mem_op, xor_acc_imm_op:
      begin
        ea = acc ^ sb;
        ef[2] = ea == 8'h0;
      end
      bitdiff_to_mem_op:
      begin
        em = acc ^ mem;
        ef[2] = em == 8'h0;
      end
      decr_acc_skip_op: begin ea = mem - 8'h1; sk = ea == 8'h0; end
      incr_skip_op: begin em = mem + 8'h1; sk = em == 8'h0; end
      incr_acc_skip_op: begin ea = mem + 8'h1; sk = ea == 8'h0; end
      set_byte_op: em = 8'hff;
      set_bit_op: em[bs] = 1'b1;
      skip_bit_high_op: sk = mem[bs];
      skip_bit_low_op: sk = !mem[bs];
      skip_on_null_op: sk = mem == 8'h0;
      copy_skip_null_op: begin ea = mem; sk = mem == 8'h0; end
      nibble_flip_op: em = {mem[3:0], mem[7:4]};
      nibble_flip_acc_op: ea = {mem[3:0], mem[7:4]};
      default:
      begin
        w = u_rom.word(op == rom_read_cur_page_op ? {pc[11:8], tp} : {4'hf, tp});
        em = w[7:0];
        th = {1'b0, w[14:8]};
      end
    endcase
  endtask

  task run(input int i);
    logic [7:0]  acc, mem, imm, ad, tp, ea, em;
    logic [5:0]  fl, ef;
    logic [11:0] pc;
    logic [2:0]  bs;
    logic        sk, tb;
    mex_op_t     op;
    int          c0, n;
    op = mex_op_t'(i % 19 + 1);
    mem = (i < 38) ? 8'($urandom) : 8'(i % 4 - 1);
    acc = (i % 5 == 0) ? mem : 8'($urandom);
    imm = (i % 5 == 0) ? acc : 8'($urandom);
    {bs, tp, fl, pc} = 29'($urandom);
    ad = 8'($urandom_range(207));
    apb(1'b1, MEX_ACC_OFS, 32'(acc));
    apb(1'b1, MEX_FLAG_OFS, 32'(fl));
    apb(1'b1, MEX_TPTR_OFS, 32'(tp));
    apb(1'b1, MEX_PC_OFS, 32'(pc));
    apb(1'b1, MEX_MADR_OFS, 32'(ad));
    apb(1'b1, MEX_MDAT_OFS, 32'(mem));
    apb(1'b1, MEX_INSTR_OFS, {imm, ad, 5'h0, bs, 3'h0, op});
    ea = acc; em = mem; ef = fl;
    calc(op, acc, mem, imm, tp, bs, pc, ea, em, tupr_last, ef, sk);
    tb = op inside {rom_read_cur_page_op, rom_read_final_page_op};
    c0 = busy_cnt;
    n = 0;
    apb(1'b1, MEX_CTRL_OFS, 32'h1);
    #1;
    while (exec_busy !== 1'b0 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    cmp("cycles", (sk || tb) ? 32'h2 : 32'h1, 32'(busy_cnt - c0));
    apb(1'b0, MEX_STAT_OFS, 32'h0);
    cmp("skip", 32'(sk), 32'(q[1]));
    apb(1'b0, MEX_ACC_OFS, 32'h0);
    cmp("acc", 32'(ea), q);
    apb(1'b0, MEX_FLAG_OFS, 32'h0);
    cmp("flags", 32'(ef), q);
    apb(1'b0, MEX_MDAT_OFS, 32'h0);
    cmp("mem", 32'(em), q);
    apb(1'b0, MEX_TUPR_OFS, 32'h0);
    cmp("upper", 32'(tupr_last), q);
    apb(1'b0, MEX_PC_OFS, 32'h0);
    cmp("pc", 32'(12'(pc + 12'h1 + 12'(sk))), q);
  endtask

  initial
  begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    nrst = 1'b0; n_fail = 0; checks = 0; busy_cnt = 0; tupr_last = 8'h0;
    void'($urandom(8578));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int k = 1; k < 10; k++)
    begin
      apb(1'b0, 12'(k * 4), 32'h0);
      cmp("reset value", 32'h0, q);
    end
    apb(1'b0, 12'h100, 32'h0);
    cmp("unmapped", 32'h1, 32'(err));
    for (int i = 0; i < 96; i++) run(i);
    report_and_stop;
  end

  // watchdog: a full run needs well under a third of this span
  initial
  begin
    #80000;
    n_fail++;
    report_and_stop;
  end
endmodule // mcu_exec_skip_sub_xor_tbl_test

bind mex_core mex_core_asserts #(.ROM_AW(ROM_AW), .ROM_DW(ROM_DW)) u_chk (.mclk(mclk),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_rdata(rom_rdata), .exec_busy(exec_busy),
  .skip_taken(skip_taken));
